// ---- sim/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench
  import vac_pkg::*;
;
  logic mclk_i, reset_i, rst_pin_n_i, bus_supply_low_i, auto_mute_req_i;
  logic scl, m_low, sda_o, sda_oe, run, ep_on, m1, m2, post, sil, skip;
  logic [3:0] gain;
  logic [1:0] ep_r;
  vac_route_e route;
  vac_bank_s bank_a, bank_b, ea, eb;
  // open drain data line with pull-up
  wire sda_w = ~(m_low | (sda_oe & ~sda_o));
  int err_count = 0, samples_checked = 0, cyc = 0;
  vac_master i_vac_master (.mclk_i(mclk_i), .sda_i(sda_w), .scl_o(scl),
    .sda_low_o(m_low));
  vac_ctrl_regs i_vac_ctrl_regs (.mclk_i(mclk_i), .reset_i(reset_i),
    .rst_pin_n_i(rst_pin_n_i), .bus_supply_low_i(bus_supply_low_i),
    .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .auto_mute_req_i(auto_mute_req_i), .run_o(run),
    .earpiece_output_on_o(ep_on), .mic_route_o(route),
    .first_mic_muted_o(m1), .second_mic_muted_o(m2),
    .post_gain_high_o(post), .input_stage_gain_o(gain),
    .earpiece_silence_o(sil), .earpiece_auto_gain_skip_o(skip),
    .earpiece_input_r_o(ep_r), .bank_a_o(bank_a), .bank_b_o(bank_b));
  // ==========================================================
  // checks and bus tasks
  task automatic end_of_test();
    $display("counts: %0d bad of %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    logic ack;
    i_vac_master.start();
    i_vac_master.xfer(adr, ack);
    chk(ack, adr == 8'hce);
    if (ack)
    begin
      i_vac_master.xfer(d, ack);
      chk(ack, 1'b1);
      if (d[7]) eb[d[6:5] * 5 +: 5] = d[4:0];
      else ea[d[6:5] * 5 +: 5] = d[4:0];
    end
    i_vac_master.stop();
  endtask
  task automatic cmp();
    @(negedge mclk_i);
    chk(bank_a, ea);
    chk(bank_b, eb);
    chk({run, ep_on}, {ea[0], ea[0] & ea[2]});
    chk(route, ea.mic_mode[4:3]);
    chk({m2, m1}, ea[7] ? {2{auto_mute_req_i}} : ea[6:5]);
    chk({post, gain}, ea.mic_gain);
    chk({sil, skip, ep_r}, {ea[19], ea[17:15]});
    @(posedge mclk_i);
  endtask
  initial
  begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 10000)
    begin
      err_count++;
      end_of_test();
    end
  end
  initial
  begin
    reset_i = 1'b1;
    rst_pin_n_i = 1'b1;
    bus_supply_low_i = 1'b0;
    auto_mute_req_i = 1'b0;
    ea = '0;
    eb = '0;
    repeat (12) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    wr(8'hcf, 8'h01);
    wr(8'hcc, 8'h01);
    cmp();
    $display("test refuse done");
    for (int i = 0; i < 8; i++)
      wr(8'hce, {i[2:0], 5'h15 ^ 5'(i)});
    cmp();
    $display("test banks done");
    for (int i = 0; i < 16; i++)
    begin
      auto_mute_req_i <= i[0];
      wr(8'hce, {3'h1, i[1:0], i[3:1]});
      cmp();
    end
    $display("test mic done");
    wr(8'hce, 8'h81);
    rst_pin_n_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    rst_pin_n_i <= 1'b1;
    ea[0] = 1'b0;
    eb[0] = 1'b0;
    repeat (20) @(posedge mclk_i);
    cmp();
    wr(8'hce, 8'h01);
    cmp();
    $display("test pin done");
    wr(8'hce, 8'h03);
    bus_supply_low_i <= 1'b1;
    repeat (5) @(posedge mclk_i);
    cmp();
    wr(8'hce, 8'h01);
    bus_supply_low_i <= 1'b0;
    ea = '0;
    eb = '0;
    cmp();
    $display("test supply done");
    end_of_test();
  end
endmodule // testbench
bind vac_ctrl_regs vac_ctrl_checker i_vac_ctrl_checker (.mclk_i(mclk_i),
  .reset_i(reset_i), .rst_pin_n_i(rst_pin_n_i), .scl_i(scl_i),
  .bus_supply_low_i(bus_supply_low_i), .sda_oe_o(sda_oe_o),
  .auto_mute_req_i(auto_mute_req_i), .run_o(run_o), .bank_a_o(bank_a_o),
  .mic_route_o(mic_route_o), .first_mic_muted_o(first_mic_muted_o),
  .bank_b_o(bank_b_o));
`default_nettype wire

// ---- sim/vac_ctrl_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module vac_ctrl_checker
  import vac_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic rst_pin_n_i,
  input wire logic bus_supply_low_i,
  input wire logic scl_i,
  input wire logic sda_oe_o,
  input wire logic auto_mute_req_i,
  input wire logic run_o,
  input wire vac_route_e mic_route_o,
  input wire logic first_mic_muted_o,
  input wire vac_bank_s bank_a_o,
  input wire vac_bank_s bank_b_o
);
  // ==========================================================
  // port relations
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  a_pin_clears: assert property (
    !rst_pin_n_i |=> !run_o && !bank_b_o.shutdown[0])
    else $error("run bit survives reset pin");
  a_pin_keeps_off: assert property (
    !rst_pin_n_i ##1 rst_pin_n_i |-> !run_o)
    else $error("run set without a write");
  a_run_by_write: assert property (
    $rose(run_o) |-> $past(rst_pin_n_i) && !scl_i)
    else $error("run rose outside a write");
  a_supply_clears: assert property (
    bus_supply_low_i && !bank_a_o.shutdown[1]
    |=> bank_a_o == '0 && bank_b_o == '0)
    else $error("low supply kept registers");
  a_supply_ignored: assert property (
    bus_supply_low_i && bank_a_o.shutdown[1] && scl_i && rst_pin_n_i
    |=> $stable(bank_a_o) && $stable(bank_b_o))
    else $error("low supply changed registers");
  a_route_field: assert property (
    mic_route_o == vac_route_e'(bank_a_o.mic_mode[4:3]))
    else $error("route differs from field");
  a_mute_gate: assert property (
    first_mic_muted_o == (bank_a_o.mic_mode[2] ?
    auto_mute_req_i : bank_a_o.mic_mode[0]))
    else $error("first mic mute wrong");
  a_ack_edges: assert property (
    $changed(sda_oe_o) |-> !scl_i)
    else $error("ack moved while clock high");
  a_ack_stands: assert property (
    sda_oe_o && scl_i |=> sda_oe_o)
    else $error("ack dropped in clock high");
  cover property ($rose(run_o));
  cover property ($rose(sda_oe_o));
  cover property (bus_supply_low_i && bank_a_o.shutdown[1]);
endmodule // vac_ctrl_checker
`default_nettype wire

// ---- sim/vac_master.sv ----
`timescale 1ns/1ps
`default_nettype none
module vac_master
(
  input wire logic mclk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // ==========================================================
  // bus master, every clock phase lasts 2 mclk or more, except the 1 mclk low phase after the dummy pulse of a start
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // scratch for the dummy pulse that opens a start
  logic start_s;
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  // data moves only while the clock is low; a 1 releases the line
  task automatic bit_x(input logic v, output logic s);
    sda_low_o <= ~v;
    tick(2);
    scl_o <= 1'b1;
    tick(2);
    s = sda_i;
    scl_o <= 1'b0;
    tick(1);
  endtask
  task automatic start();
    bit_x(1'b1, start_s);
    scl_o <= 1'b1;
    tick(2);
    sda_low_o <= 1'b1;
    tick(2);
    scl_o <= 1'b0;
    tick(1);
  endtask
  task automatic stop();
    sda_low_o <= 1'b1;
    tick(2);
    scl_o <= 1'b1;
    tick(2);
    sda_low_o <= 1'b0;
    tick(2);
  endtask
  task automatic xfer(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_x(b[i], s);
    bit_x(1'b1, s);
    ack = ~s;
  endtask
endmodule // vac_master
`default_nettype wire

// ---- verilog/vac_bank_store.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "vac_cfg.svh"

module vac_bank_store
  import vac_pkg::*;
(
  input wire logic mclk_i,
  input wire logic clear_all_i,
  input wire logic clear_run_i,
  input wire logic wr_en_i,
  input wire vac_wr_s wr_i,
  output vac_bank_s bank_a_o,
  output vac_bank_s bank_b_o
);

  // ==========================================================
  // storage: index is {bank, select}
  logic [4:0] mem_q [0:7];
  logic [2:0] wr_idx;

  assign wr_idx = {wr_i.bank, wr_i.sel};

  always_ff @(posedge mclk_i)
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (clear_all_i)
        mem_q[i] <= `VAC_REG_RESET;
      else if (clear_run_i && i[1:0] == `VAC_REG_SHUTDOWN)
        mem_q[i] <= mem_q[i] & ~(5'h01 << `VAC_SD_RUN_BIT); // [RQ1]
      else if (wr_en_i && wr_idx == i[2:0])
        mem_q[i] <= wr_i.payload;
    end
  end

  assign bank_a_o = {mem_q[3], mem_q[2], mem_q[1], mem_q[0]};
  assign bank_b_o = {mem_q[7], mem_q[6], mem_q[5], mem_q[4]};

endmodule // vac_bank_store

`default_nettype wire

// ---- verilog/vac_cfg.svh ----
`ifndef VAC_CFG_SVH
`define VAC_CFG_SVH

// ==========================================================
// bus address and data byte layout
`define VAC_DEV_ADDR 7'h67
`define VAC_BANK_BIT 7
`define VAC_SEL_HI 6
`define VAC_SEL_LO 5
`define VAC_PAY_HI 4

// ==========================================================
// register selects
`define VAC_REG_SHUTDOWN 2'h0
`define VAC_REG_MIC_MODE 2'h1
`define VAC_REG_MIC_GAIN 2'h2
`define VAC_REG_EARPIECE 2'h3

// ==========================================================
// field positions
`define VAC_SD_EP_ON_BIT 2
`define VAC_SD_SUPPLY_DIS_BIT 1
`define VAC_SD_RUN_BIT 0
`define VAC_MM_ROUTE_HI 4
`define VAC_MM_ROUTE_LO 3
`define VAC_MM_PERMIT_BIT 2
`define VAC_MM_MIC2_BIT 1
`define VAC_MM_MIC1_BIT 0
`define VAC_MG_POST_BIT 4
`define VAC_MG_PRE_HI 3
`define VAC_EP_SILENCE_BIT 4
`define VAC_EP_SKIP_BIT 2

// ==========================================================
// reset values
`define VAC_REG_RESET 5'h00

`endif

// ---- verilog/vac_ctrl_regs.sv ----
// Function
// [RQ1] a low reset pin forces shutdown by clearing the run-enable bit.
// [RQ2] after that the device stays shut down until a write sets run-enable.
// [RQ3] with supply-reset-disable at 0, low bus supply restores all defaults.
// [RQ4] with supply-reset-disable at 1, bus supply level causes no reset.
// [RQ5] data bit 7 picks bank A or bank B for the write.
// [RQ6] the route field picks cancel, mic1 only, mic2 only or average.
// [RQ7] auto-mute-permit at 0 forbids automatic muting, at 1 permits it.
// [RQ8] per-mic silence bits mute their mic, overridden by auto-mute-permit.
// [RQ9] gain register, select 10, holds post gain in bit 4, pre gain in 3:0.
// [RQ10] only address 1100111 with a write bit of 0 is answered.
// [RQ11] data bits 6:5 pick shutdown, mic mode, mic gain or earpiece.
// [RQ12] only writes are accepted; a read request gets no answer.
// [RQ13] the device acknowledges its address and each data byte.
`timescale 1ns/1ps
`default_nettype none
`include "vac_cfg.svh"

module vac_ctrl_regs
  import vac_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic rst_pin_n_i,
  input wire logic bus_supply_low_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic auto_mute_req_i,
  output logic run_o,
  output logic earpiece_output_on_o,
  output vac_route_e mic_route_o,
  output logic first_mic_muted_o,
  output logic second_mic_muted_o,
  output logic post_gain_high_o,
  output logic [3:0] input_stage_gain_o,
  output logic earpiece_silence_o,
  output logic earpiece_auto_gain_skip_o,
  output logic [1:0] earpiece_input_r_o,
  output vac_bank_s bank_a_o,
  output vac_bank_s bank_b_o
);

  typedef enum logic [2:0] {
    VAC_IDLE,
    VAC_ADDR,
    VAC_ACK_ADDR,
    VAC_DATA,
    VAC_ACK_DATA
  } vac_state_e;

  // ==========================================================
  // shared state decodes
  // states in which the data line is held low for an acknowledge
  function automatic logic is_ack(input vac_state_e s);
    is_ack = (s == VAC_ACK_ADDR) || (s == VAC_ACK_DATA);
  endfunction

  // states in which bus bits are shifted in
  function automatic logic is_rx(input vac_state_e s);
    is_rx = (s == VAC_ADDR) || (s == VAC_DATA);
  endfunction

  // ==========================================================
  // bus line edge detection
  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  assign scl_rise = scl_i & ~scl_q;
  assign scl_fall = ~scl_i & scl_q;
  assign start_seen = scl_i & scl_q & sda_q & ~sda_i;
  assign stop_seen = scl_i & scl_q & ~sda_q & sda_i;

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  // ==========================================================
  // byte receiver
  vac_state_e state_q;
  vac_state_e state_d;
  logic [7:0] shift_q;
  logic [3:0] nbits_q;
  logic byte_full;
  logic byte_done;
  logic bit_take;
  logic addr_match;
  logic wr_en;
  vac_wr_s wr_word;

  assign byte_full = (nbits_q == 4'h8);
  // the ninth rising edge is the acknowledge slot, never shifted in
  assign bit_take = scl_rise && !byte_full && is_rx(state_q);
  // a byte is closed on the falling clock edge after its eighth bit
  assign byte_done = byte_full && scl_fall;
  // bit 0 is the direction; a read request fails the match
  assign addr_match = (shift_q == {`VAC_DEV_ADDR, 1'b0}); // [RQ10] [RQ12]
  assign wr_en = (state_q == VAC_DATA) && byte_done;
  assign wr_word.bank = shift_q[`VAC_BANK_BIT]; // [RQ5]
  assign wr_word.sel = shift_q[`VAC_SEL_HI:`VAC_SEL_LO]; // [RQ11]
  assign wr_word.payload = shift_q[`VAC_PAY_HI:0];

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      VAC_IDLE: ;
      VAC_ADDR:
        if (byte_done)
          state_d = addr_match ? VAC_ACK_ADDR : VAC_IDLE; // [RQ12]
      VAC_ACK_ADDR:
        if (scl_fall)
          state_d = VAC_DATA;
      VAC_DATA:
        if (wr_en)
          state_d = VAC_ACK_DATA;
      VAC_ACK_DATA:
        if (scl_fall)
          state_d = VAC_DATA;
      default:
        state_d = VAC_IDLE;
    endcase
    if (stop_seen)
      state_d = VAC_IDLE;
    if (start_seen)
      state_d = VAC_ADDR;
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      state_q <= VAC_IDLE;
    else
      state_q <= state_d;
  end

  // bit count restarts at a start and after every acknowledge slot
  always_ff @(posedge mclk_i)
  begin
    if (reset_i || start_seen || is_ack(state_d))
      nbits_q <= 4'h0;
    else if (bit_take)
      nbits_q <= nbits_q + 4'h1;
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      shift_q <= 8'h00;
    else if (bit_take)
      shift_q <= {shift_q[6:0], sda_i};
  end

  // ack is driven from the falling edge after bit 8 to the next one
  assign sda_o = 1'b0;
  // taken from the state register so the pull never glitches
  assign sda_oe_o = is_ack(state_q); // [RQ13]

  // ==========================================================
  // reset sources and register store
  logic supply_reset;
  logic pin_shutdown;

  // the disable bit is taken from bank A, which also drives the outputs
  // limitation: the supply flag is trusted as a clean level, no filter
  assign supply_reset = bus_supply_low_i &&
    !bank_a_o.shutdown[`VAC_SD_SUPPLY_DIS_BIT]; // [RQ3] [RQ4]
  // pin held low also blocks a run-enable write in the same cycle
  assign pin_shutdown = !rst_pin_n_i; // [RQ1] [RQ2]

  vac_bank_store u_store (
    .mclk_i(mclk_i),
    .clear_all_i(reset_i || supply_reset), // [RQ3]
    .clear_run_i(pin_shutdown),
    .wr_en_i(wr_en && !reset_i),
    .wr_i(wr_word),
    .bank_a_o(bank_a_o),
    .bank_b_o(bank_b_o)
  );

  // ==========================================================
  // decoded controls from the active bank (A)
  // bank B is kept and shown only; nothing here acts on it
  logic permit;

  assign permit = bank_a_o.mic_mode[`VAC_MM_PERMIT_BIT];
  assign run_o = bank_a_o.shutdown[`VAC_SD_RUN_BIT]; // [RQ2]
  assign earpiece_output_on_o = run_o &&
    bank_a_o.shutdown[`VAC_SD_EP_ON_BIT];
  assign mic_route_o = vac_route_e'(
    bank_a_o.mic_mode[`VAC_MM_ROUTE_HI:`VAC_MM_ROUTE_LO]); // [RQ6]
  // permit hands muting to the automatic request, silence bits ignored
  assign first_mic_muted_o = permit ? auto_mute_req_i :
    bank_a_o.mic_mode[`VAC_MM_MIC1_BIT]; // [RQ7] [RQ8]
  assign second_mic_muted_o = permit ? auto_mute_req_i :
    bank_a_o.mic_mode[`VAC_MM_MIC2_BIT]; // [RQ7] [RQ8]
  assign post_gain_high_o = bank_a_o.mic_gain[`VAC_MG_POST_BIT]; // [RQ9]
  assign input_stage_gain_o = bank_a_o.mic_gain[`VAC_MG_PRE_HI:0]; // [RQ9]
  assign earpiece_silence_o = bank_a_o.earpiece[`VAC_EP_SILENCE_BIT];
  assign earpiece_auto_gain_skip_o = bank_a_o.earpiece[`VAC_EP_SKIP_BIT];
  assign earpiece_input_r_o = bank_a_o.earpiece[1:0];

endmodule // vac_ctrl_regs

`default_nettype wire

// ---- verilog/vac_pkg.sv ----
package vac_pkg;

  typedef enum logic [1:0] {
    VAC_ROUTE_CANCEL,
    VAC_ROUTE_MIC1,
    VAC_ROUTE_MIC2,
    VAC_ROUTE_AVG
  } vac_route_e;

  // one register write decoded from a data byte
  typedef struct packed {
    logic bank;
    logic [1:0] sel;
    logic [4:0] payload;
  } vac_wr_s;

  // the four registers of one bank
  typedef struct packed {
    logic [4:0] earpiece;
    logic [4:0] mic_gain;
    logic [4:0] mic_mode;
    logic [4:0] shutdown;
  } vac_bank_s;

endpackage
